// ### sces_host_model.sv
`timescale 1ns/1ns
// Host end of the command port; it drives at the falling edge
module sces_host_model (
	input  wire logic       clk,      // System clock
	input  wire logic       ready,    // Device waits for a command
	output logic            cmdValid, // Command byte present
	output logic [7:0]      cmdIn     // Command byte
);
	bit stalled = 1'b0; // Set when ready never came back
	initial begin
		cmdValid = 1'b0;
		cmdIn    = 8'h00;
	end
	// One handshake; the byte is inverted after release so stale data
	// is never mistaken for a live command
	task automatic issue(input logic [7:0] cmd);
		int n;
		n = 0;
		@(negedge clk);
		while (ready !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		// A stuck ready must not pass quietly; the bench counts it
		if (n >= 100) stalled = 1'b1;
		cmdValid = 1'b1;
		cmdIn    = cmd;
		@(negedge clk);
		cmdValid = 1'b0;
		cmdIn    = ~cmd;
		repeat (2) @(negedge clk);
	endtask : issue
endmodule : sces_host_model

// ### sces_pkg.sv
package sces_pkg;

	// ********************************************************
	// Command port layout
	// ********************************************************
	localparam int OP_MSB = 7;
	localparam int OP_LSB = 4;
	localparam logic [3:0] OP_SET_ENABLE = 4'h1; // Arg = cause enables
	localparam logic [3:0] OP_READ_CAUSE = 4'h2; // Returns cause status
	localparam logic [3:0] OP_READ_KEY   = 4'h3; // Returns keyboard byte
	localparam logic [3:0] OP_SET_ANALOG = 4'h4; // Arg bit0 = current mode
	localparam logic [3:0] OP_SET_TONE   = 4'h5; // Arg bit0 click, bit1 alarm
	localparam int ARG_CLICK = 0;
	localparam int ARG_ALARM = 1;
	localparam logic [7:0] RET_IDLE = 8'h00;

	// ********************************************************
	// Reset values
	// ********************************************************
	localparam logic RST_ANALOG_CURRENT = 1'b0; // Voltage mode after init

	// ********************************************************
	// Timing, clock 100 MHz
	// ********************************************************
	localparam longint CLK_PERIOD_NS   = 10;
	localparam longint TICK_PERIOD_NS  = 15625000;    // 1/64 s
	localparam longint HALF_SEC_NS     = 500000000;   // 0.5 s
	localparam longint TONE_PERIOD_NS  = 500000;      // 2 kHz tone
	localparam longint CLICK_LEN_NS    = 10000000;    // 10 ms click
	localparam longint TICK_HALF_CYC   = TICK_PERIOD_NS / 2 / CLK_PERIOD_NS;
	localparam longint HALF_SEC_CYC    = HALF_SEC_NS / CLK_PERIOD_NS;
	localparam longint TONE_HALF_CYC   = TONE_PERIOD_NS / 2 / CLK_PERIOD_NS;
	localparam longint CLICK_CYC       = CLICK_LEN_NS / CLK_PERIOD_NS;
	localparam int TICK_W  = 20;
	localparam int HALF_W  = 26;
	localparam int TONE_W  = 15;
	localparam int CLICK_W = 20;

	// ********************************************************
	// Types
	// ********************************************************
	typedef struct packed {
		logic halfSec;  // 0.5 s period of the real-time timer
		logic keyIn;    // External keyboard input arrived
		logic alarm;    // Alarm-1 or alarm-2 match
		logic wake;     // Wake-up time match
	} sces_cause_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_FIN  = 2'b11
	} sces_state_t;

endpackage : sces_pkg

// ### sces_top.sv
`timescale 1ns/1ns
module sces_top
	import sces_pkg::*;
#(
	parameter int TICK_HALF  = int'(TICK_HALF_CYC),
	parameter int HALF_SEC   = int'(HALF_SEC_CYC),
	parameter int TONE_HALF  = int'(TONE_HALF_CYC),
	parameter int CLICK_LEN  = int'(CLICK_CYC)
) (
	input  wire logic        clk,            // System clock
	input  wire logic        reset_n,        // Async reset, active low
	input  wire logic        cmdValid,       // Command byte present
	input  wire logic [7:0]  cmdIn,          // Command from host
	input  wire logic        wakeMatch,      // Timer equals wake-up time
	input  wire logic        alarm1Match,    // Timer equals alarm-1
	input  wire logic        alarm2Match,    // Timer equals alarm-2
	input  wire logic        extKeyValid,    // Keyboard byte arrives
	input  wire logic [7:0]  extKeyData,     // Keyboard byte
	output logic             cmd_ready_out,  // Waiting for command
	output logic             cmd_done_out,   // Command finished pulse
	output logic [7:0]       retData,        // Return data to host
	output logic             irqOut,         // Interrupt request
	output logic             analogModeOut,  // High selects current
	output logic             tick_square_out,// 1/64 s square wave
	output logic             toneOut         // Click and alarm sound
);

	// ********************************************************
	// Reset release
	// ********************************************************
	logic [1:0] rstSync;
	logic       rstN;

	// Two stages so release is clean against clk
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) rstSync <= 2'h0;
		else rstSync <= {rstSync[0], 1'b1};
	end
	assign rstN = rstSync[1];

	function automatic logic [3:0] opOf(input logic [7:0] c);
		opOf = c[OP_MSB:OP_LSB];
	endfunction : opOf

	// ********************************************************
	// Command sequencer and event state
	// ********************************************************
	sces_state_t state, next_state;
	logic [7:0]  cmdHeld, next_cmdHeld;
	sces_cause_t cause, next_cause, enable, next_enable, events;
	logic [7:0]  keyData, next_keyData;
	logic        next_ready, next_done, next_irq, next_analog;
	logic [7:0]  next_retData;
	logic        alarmOn, next_alarmOn;
	logic [CLICK_W-1:0] clickCnt, next_clickCnt;
	logic [HALF_W-1:0]  halfCnt, next_halfCnt;
	logic        take, execStatus, execKey;

	assign take       = cmdValid && cmd_ready_out;
	assign execStatus = (state == ST_EXEC) && (opOf(cmdHeld) == OP_READ_CAUSE);
	assign execKey    = (state == ST_EXEC) && (opOf(cmdHeld) == OP_READ_KEY);

	// Sequencer; set of a cause wins over a clear in the same cycle
	always_comb begin
		next_state    = state;
		next_cmdHeld  = cmdHeld;
		next_enable   = enable;
		next_keyData  = keyData;
		next_retData  = retData;
		next_analog   = analogModeOut;
		next_alarmOn  = alarmOn;
		next_clickCnt = (clickCnt != '0) ? clickCnt - 1'b1 : clickCnt;
		next_halfCnt  = (halfCnt == HALF_W'(HALF_SEC - 1)) ? '0 :
		                halfCnt + 1'b1;
		events.wake    = wakeMatch;
		events.alarm   = alarm1Match || alarm2Match;
		events.keyIn   = extKeyValid;
		events.halfSec = (halfCnt == HALF_W'(HALF_SEC - 1));
		next_cause = cause;
		if (execStatus) next_cause = '0;
		if (execKey) next_cause.keyIn = 1'b0;
		next_cause = next_cause | events;
		if (extKeyValid) next_keyData = extKeyData;
		unique case (state)
			ST_IDLE: begin
				if (take) begin
					next_cmdHeld = cmdIn;
					next_state   = ST_EXEC;
				end
			end
			ST_EXEC: begin
				next_state = ST_FIN;
				unique case (opOf(cmdHeld))
					OP_SET_ENABLE: next_enable = sces_cause_t'(cmdHeld[3:0]);
					OP_READ_CAUSE: begin
						next_retData = {4'h0, cause};
						next_analog  = 1'b0;
					end
					OP_READ_KEY: next_retData = keyData;
					OP_SET_ANALOG: next_analog = cmdHeld[0];
					OP_SET_TONE: begin
						next_alarmOn = cmdHeld[ARG_ALARM];
						if (cmdHeld[ARG_CLICK])
							next_clickCnt = CLICK_W'(CLICK_LEN);
					end
					default: next_retData = RET_IDLE;
				endcase
			end
			ST_FIN: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
		next_ready = (next_state == ST_IDLE);
		next_done  = (next_state == ST_FIN);
		next_irq   = |(next_cause & next_enable);
	end

	// Registers for the sequencer group
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			state         <= ST_IDLE;
			cmdHeld       <= 8'h00;
			enable        <= '0;
			cause         <= '0;
			keyData       <= 8'h00;
			retData       <= RET_IDLE;
			analogModeOut <= RST_ANALOG_CURRENT;
			alarmOn       <= 1'b0;
			clickCnt      <= '0;
			halfCnt       <= '0;
			cmd_ready_out <= 1'b0;
			cmd_done_out  <= 1'b0;
			irqOut        <= 1'b0;
		end else begin
			state         <= next_state;
			cmdHeld       <= next_cmdHeld;
			enable        <= next_enable;
			cause         <= next_cause;
			keyData       <= next_keyData;
			retData       <= next_retData;
			analogModeOut <= next_analog;
			alarmOn       <= next_alarmOn;
			clickCnt      <= next_clickCnt;
			halfCnt       <= next_halfCnt;
			cmd_ready_out <= next_ready;
			cmd_done_out  <= next_done;
			irqOut        <= next_irq;
		end
	end

	// ********************************************************
	// Square wave and tone dividers
	// ********************************************************
	logic [TICK_W-1:0] tickCnt, next_tickCnt;
	logic [TONE_W-1:0] toneCnt, next_toneCnt;
	logic              next_tick, next_tone, toneOn;

	// Tone only free-runs while a sound is wanted, so it idles low
	assign toneOn = alarmOn || (clickCnt != '0);

	always_comb begin
		next_tickCnt = tickCnt + 1'b1;
		next_tick    = tick_square_out;
		if (tickCnt == TICK_W'(TICK_HALF - 1)) begin
			next_tickCnt = '0;
			next_tick    = !tick_square_out;
		end
		next_toneCnt = toneCnt + 1'b1;
		next_tone    = toneOut;
		if (!toneOn) begin
			next_toneCnt = '0;
			next_tone    = 1'b0;
		end else if (toneCnt == TONE_W'(TONE_HALF - 1)) begin
			next_toneCnt = '0;
			next_tone    = !toneOut;
		end
	end

	// Registers for the divider group
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			tickCnt         <= '0;
			tick_square_out <= 1'b0;
			toneCnt         <= '0;
			toneOut         <= 1'b0;
		end else begin
			tickCnt         <= next_tickCnt;
			tick_square_out <= next_tick;
			toneCnt         <= next_toneCnt;
			toneOut         <= next_tone;
		end
	end

	// ********************************************************
	// Assertions
	// ********************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstN);

	a_cmd_handshake: assert property (take |=> !cmd_ready_out
		##1 (cmd_done_out && !cmd_ready_out)
		##1 (cmd_ready_out && !cmd_done_out))
		else $error("command handshake out of sequence");
	a_done_single: assert property (cmd_done_out |=> !cmd_done_out)
		else $error("done pulse longer than one cycle");
	a_irq_enabled: assert property (irqOut |-> |(cause & enable))
		else $error("interrupt without enabled cause");
	a_wake_raise: assert property (wakeMatch && next_enable.wake
		|=> irqOut)
		else $error("wake-up match did not raise interrupt");
	a_alarm_raise: assert property ((alarm1Match || alarm2Match)
		&& next_enable.alarm |=> irqOut)
		else $error("alarm match did not raise interrupt");
	a_key_raise: assert property (extKeyValid && next_enable.keyIn
		|=> irqOut)
		else $error("keyboard input did not raise interrupt");
	a_status_clear: assert property ((take && opOf(cmdIn) ==
		OP_READ_CAUSE) ##1 (events == '0) |=> !irqOut && !analogModeOut)
		else $error("status read did not clear outputs");
	a_analog_rise: assert property ($rose(analogModeOut) |->
		$past(state) == ST_EXEC && $past(opOf(cmdHeld)) == OP_SET_ANALOG)
		else $error("analog mode rose without command");
	a_tick_steady: assert property ($changed(tick_square_out) |->
		$past(tickCnt) == TICK_W'(TICK_HALF - 1))
		else $error("square wave toggled off its period");
	a_tone_silent: assert property (!toneOn |=> !toneOut)
		else $error("tone output active while silent");

	c_status_read: cover property (take && opOf(cmdIn) == OP_READ_CAUSE
		##2 cmd_done_out);
	c_key_drain: cover property (irqOut ##1 execKey ##1 !irqOut);
	c_alarm_tone: cover property (alarmOn && $rose(toneOut));
	c_tick_toggle: cover property ($fell(tick_square_out));

endmodule : sces_top

// ### sces_top_bench.sv
`timescale 1ns/1ns
module sces_top_bench;
	import sces_pkg::*;
	logic        clk, reset_n, wakeMatch, alarm1Match, alarm2Match;
	logic        extKeyValid, cmdValid, ready, done, irqOut;
	logic        analogModeOut, tickOut, toneOut;
	logic [7:0]  extKeyData, cmdIn, retData;
	logic [15:0] lfsr = 16'h2235;
	logic [15:0] expQ[$];
	logic [15:0] e;
	int          miscompares = 0;
	int          checked = 0;
	int          hi, lo;

	sces_top #(.TICK_HALF(4), .HALF_SEC(50), .TONE_HALF(3), .CLICK_LEN(20))
	u_dut (.clk(clk), .reset_n(reset_n), .cmdValid(cmdValid), .cmdIn(cmdIn),
		.wakeMatch(wakeMatch), .alarm1Match(alarm1Match),
		.alarm2Match(alarm2Match), .extKeyValid(extKeyValid),
		.extKeyData(extKeyData), .cmd_ready_out(ready), .cmd_done_out(done),
		.retData(retData), .irqOut(irqOut), .analogModeOut(analogModeOut),
		.tick_square_out(tickOut), .toneOut(toneOut));
	sces_host_model u_host (.clk(clk), .ready(ready), .cmdValid(cmdValid),
		.cmdIn(cmdIn));

	// ************************************************
	// Helpers
	// ************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic fail(input string msg);
		miscompares++;
		$display("ERROR %0t %s", $time, msg);
	endtask : fail
	task automatic cmp_bit(input logic got, input logic exp, input string m);
		checked++;
		if (got !== exp) fail(m);
	endtask : cmp_bit
	task automatic cmp_cnt(input int got, input int exp, input string m);
		checked++;
		if (got != exp) fail(m);
	endtask : cmp_cnt
	// Note holds mask in the upper byte, expected return in the lower
	task automatic cmp_ret(input logic [15:0] n);
		checked++;
		if ((retData & n[15:8]) !== (n[7:0] & n[15:8])) fail("return byte");
	endtask : cmp_ret
	// Random source for keyboard bytes, seeded at the top
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr_next
	task automatic wrap_up();
		if (expQ.size() != 0) fail("missing done pulse");
		if (u_host.stalled) fail("host never saw ready");
		$display("miscompares=%0d checked=%0d", miscompares, checked);
		if (miscompares == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up
	// Each done pulse consumes the oldest note
	always @(negedge clk) begin
		if (done === 1'B1) begin
			if (expQ.size() == 0) begin
				fail("unexpected done");
			end else begin
				e = expQ.pop_front();
				cmp_ret(e);
			end
		end
	end
	task automatic cmd(input logic [7:0] c, input logic [15:0] n);
		expQ.push_back(n);
		u_host.issue(c);
	endtask : cmd
	// One-cycle event pulse, then one more edge for the request
	task automatic pulse(input int w);
		@(negedge clk);
		wakeMatch   = (w == 0);
		alarm1Match = (w == 1);
		alarm2Match = (w == 2);
		extKeyValid = (w == 3);
		@(negedge clk);
		{wakeMatch, alarm1Match, alarm2Match, extKeyValid} = 4'h0;
		extKeyData = ~extKeyData;
		@(negedge clk);
	endtask : pulse
	function automatic logic sig(input int s);
		return (s != 0) ? toneOut : tickOut;
	endfunction : sig
	// High and low run lengths of one full period, in cycles
	task automatic halves(input int s, output int h, output int l);
		h = 0;
		l = 0;
		repeat (200) begin @(negedge clk); if (sig(s) === 1'b0) break; end
		repeat (200) begin @(negedge clk); if (sig(s) === 1'b1) break; end
		while (sig(s) === 1'b1 && h < 99) begin h++; @(negedge clk); end
		while (sig(s) === 1'b0 && l < 99) begin l++; @(negedge clk); end
	endtask : halves

	// ************************************************
	// Scenarios
	// ************************************************
	initial begin
		{reset_n, wakeMatch, alarm1Match, alarm2Match, extKeyValid} = 5'h00;
		extKeyData = 8'h00;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
		cmp_bit(analogModeOut, 1'b0, "analog init");
		cmp_bit(ready, 1'b1, "ready idle");
		cmd(8'h41, 16'hFF00);
		cmp_bit(analogModeOut, 1'b1, "analog current");
		cmd(8'h17, 16'hFF00);
		cmd(8'h20, 16'hFF00);
		cmp_bit(analogModeOut, 1'b0, "analog after status");
		for (int i = 0; i < 3; i++) begin
			pulse(i);
			cmp_bit(irqOut, 1'b1, "irq raise");
			cmd(8'h20, {8'h07, (i == 0) ? 8'h01 : 8'h02});
			cmp_bit(irqOut, 1'b0, "irq drop");
		end
		for (int k = 0; k < 3; k++) begin
			lfsr = lfsr_next(lfsr);
			extKeyData = lfsr[7:0];
			pulse(3);
			cmp_bit(irqOut, 1'b1, "key irq");
			cmd(8'h30, {8'hFF, ~extKeyData});
			cmp_bit(irqOut, 1'b0, "key drained");
		end
		cmd(8'h10, 16'h0000);
		pulse(0);
		cmp_bit(irqOut, 1'b0, "disabled cause");
		cmd(8'h20, 16'h0101);
		cmd(8'h18, 16'h0000);
		repeat (60) begin @(negedge clk); if (irqOut === 1'b1) break; end
		cmp_bit(irqOut, 1'b1, "half second irq");
		cmd(8'h20, 16'h0808);
		cmp_bit(irqOut, 1'b0, "half second drop");
		cmd(8'hF3, 16'hFF00);
		halves(0, hi, lo);
		cmp_cnt(hi, 4, "tick high");
		cmp_cnt(lo, 4, "tick low");
		cmd(8'h51, 16'hFF00);
		halves(1, hi, lo);
		cmp_cnt(hi + lo, 6, "click period");
		repeat (40) @(negedge clk);
		cmp_bit(toneOut, 1'b0, "click ended");
		cmd(8'h52, 16'hFF00);
		halves(1, hi, lo);
		cmp_cnt(hi + lo, 6, "alarm period");
		cmd(8'h50, 16'hFF00);
		repeat (10) @(negedge clk);
		cmp_bit(toneOut, 1'b0, "alarm off");
		wrap_up();
	end
	// Watchdog well beyond the few hundred cycles the run needs
	initial begin
		#100000;
		fail("watchdog");
		wrap_up();
	end
endmodule : sces_top_bench
